/* File: core/cyclic_counter_pkg.sv */
// Package with constants and types for the cyclic counter with compare and PWM
package cyclic_counter_pkg;
  localparam int COUNT_W = 10;
  localparam logic [9:0] COUNT_RESET = 10'h000;
  localparam logic [9:0] ALL_ONES_10 = 10'h3FF;
  // Length masks for 10, 8, 6 and 4 bits
  localparam logic [9:0] MASK_LEN_10 = 10'h3FF;
  localparam logic [9:0] MASK_LEN_8 = 10'h0FF;
  localparam logic [9:0] MASK_LEN_6 = 10'h03F;
  localparam logic [9:0] MASK_LEN_4 = 10'h00F;
  // Clock source codes
  localparam logic [2:0] SRC_PORTA_ZERO = 3'h0;
  localparam logic [2:0] SRC_PORTA_THREE = 3'h7;
  localparam int SYNC_STAGES = 3;
  localparam int PRESC_TAPS = 6;

  typedef struct packed {
    logic [2:0] count_clock_source_select;
    logic count_up;
    logic start;
    logic event_count_enable;
    logic full_width_compare_select;
    logic pwm_route_enable;
    logic [1:0] length_select;
  } counter_config_t;

  typedef struct packed {
    logic [1:0] porta_edge_invert;
    logic [1:0] porta_debounce_disable;
  } porta_option_t;
endpackage : cyclic_counter_pkg

/* File: core/cyclic_counter_compare_pwm.sv */
// Ten-bit cyclic counter with compare, event count and PWM output
`timescale 1ns/10ps
`default_nettype none

module cyclic_counter_compare_pwm
  import cyclic_counter_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Configuration
  input wire counter_config_t cfg,
  input wire porta_option_t porta_opt,
  input wire logic [9:0] preset_compare_value,
  // Software strobes, one cycle each
  input wire logic load_strobe,
  input wire logic compare_enable_set,
  input wire logic compare_enable_clear,
  // Prescaler taps (ascending selects 1..6) and debounce clocks
  input wire logic [5:0] presc_tap,
  input wire logic [1:0] debounce_tick,
  // Pins
  input wire logic porta_bit_zero_pin,
  input wire logic porta_bit_three_pin,
  input wire logic portb_data_out,
  output logic portb_bit_three_pin,
  // State and events
  output logic [9:0] count_value,
  output logic compare_enable,
  output logic start_cleared,
  output logic rollover_irq,
  output logic match_irq
);

  // ----------------------------------------------------------------
  // Pin synchronisers and debounce
  // ----------------------------------------------------------------
  logic [SYNC_STAGES-1:0] pa_sync_reg [2];
  logic [1:0] pa_stable_reg;
  logic [1:0] pa_deb_reg;
  logic [1:0] pa_clk;
  logic [1:0] pa_raw;
  logic [1:0] half_reg;

  assign pa_raw = {porta_bit_three_pin, porta_bit_zero_pin};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pa
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          pa_sync_reg[g] <= '0;
          pa_stable_reg[g] <= 1'b0;
        end else begin
          pa_sync_reg[g] <= {pa_sync_reg[g][1:0], pa_raw[g]};
          if (pa_sync_reg[g][1] == pa_sync_reg[g][2]) begin
            pa_stable_reg[g] <= pa_sync_reg[g][2];
          end
        end
      end
      // Debouncer samples only on its slow tick
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          pa_deb_reg[g] <= 1'b0;
        end else if (debounce_tick[g]) begin
          pa_deb_reg[g] <= pa_stable_reg[g];
        end
      end
      assign pa_clk[g] = (porta_opt.porta_debounce_disable[g] ? pa_stable_reg[g] : pa_deb_reg[g])
                         ^ porta_opt.porta_edge_invert[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Count clock selection
  // ----------------------------------------------------------------
  logic sel_pin;
  logic sel_idx;
  logic sel_clk;
  logic sel_clk_prev_reg;
  logic sel_rise;
  logic sel_fall;
  logic pin_prev_reg;
  logic pin_fall;
  logic half_prev_reg;
  logic half_rise;
  logic eff_clk;

  assign sel_pin = (cfg.count_clock_source_select == SRC_PORTA_ZERO) ||
                   (cfg.count_clock_source_select == SRC_PORTA_THREE);
  assign sel_idx = (cfg.count_clock_source_select == SRC_PORTA_THREE);

  // Undebounced pin clock is divided by two on falling edges
  assign pin_fall = pin_prev_reg & ~pa_clk[sel_idx];
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_prev_reg <= 1'b0;
      half_reg <= 2'b00;
    end else begin
      pin_prev_reg <= pa_clk[sel_idx];
      if (sel_pin && pin_fall) begin
        half_reg[sel_idx] <= ~half_reg[sel_idx];
      end
    end
  end

  always_comb begin
    sel_clk = 1'b0;
    case (cfg.count_clock_source_select)
      SRC_PORTA_ZERO, SRC_PORTA_THREE: begin
        if (porta_opt.porta_debounce_disable[sel_idx]) begin
          sel_clk = half_reg[sel_idx];
        end else begin
          sel_clk = pa_clk[sel_idx];
        end
      end
      default: begin
        sel_clk = presc_tap[cfg.count_clock_source_select - 3'h1];
      end
    endcase
  end

  assign eff_clk = sel_clk;
  assign sel_rise = eff_clk & ~sel_clk_prev_reg;
  assign sel_fall = ~eff_clk & sel_clk_prev_reg;
  assign half_rise = 1'b0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_clk_prev_reg <= 1'b0;
      half_prev_reg <= 1'b0;
    end else begin
      sel_clk_prev_reg <= eff_clk;
      half_prev_reg <= half_rise;
    end
  end

  // ----------------------------------------------------------------
  // Start synchronisation
  // ----------------------------------------------------------------
  logic fall_latched_reg;
  logic running_reg;
  logic auto_stop_reg;
  logic run_gate;

  assign run_gate = cfg.start & ~auto_stop_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fall_latched_reg <= 1'b0;
      running_reg <= 1'b0;
    end else if (!run_gate) begin
      fall_latched_reg <= 1'b0;
      running_reg <= 1'b0;
    end else if (cfg.event_count_enable) begin
      running_reg <= 1'b1;
    end else begin
      if (sel_fall) begin
        fall_latched_reg <= 1'b1;
      end
      if (sel_rise && fall_latched_reg) begin
        running_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic [9:0] count_reg;
  logic [9:0] count_next;
  logic [9:0] len_mask;
  logic [9:0] irq_mask;
  logic count_step;
  logic count_up_prev_reg;

  always_comb begin
    case (cfg.length_select)
      2'b00: len_mask = MASK_LEN_10;
      2'b01: len_mask = MASK_LEN_8;
      2'b10: len_mask = MASK_LEN_6;
      2'b11: len_mask = MASK_LEN_4;
      default: len_mask = MASK_LEN_10;
    endcase
  end

  assign irq_mask = cfg.full_width_compare_select ? ALL_ONES_10 : len_mask;
  assign count_step = running_reg & sel_rise & run_gate;
  assign count_next = cfg.count_up ? count_reg + 10'h001 : count_reg - 10'h001;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_reg <= COUNT_RESET;
      count_up_prev_reg <= 1'b0;
    end else begin
      count_up_prev_reg <= cfg.count_up;
      if (load_strobe) begin
        count_reg <= preset_compare_value;
      end else if (cfg.count_up != count_up_prev_reg) begin
        count_reg <= ~count_reg;
      end else if (count_step) begin
        count_reg <= count_next;
      end
    end
  end

  assign count_value = count_reg;
  assign start_cleared = load_strobe && (preset_compare_value == COUNT_RESET);

  // ----------------------------------------------------------------
  // Compare enable and events
  // ----------------------------------------------------------------
  logic compare_enable_reg;
  logic roll_hit;
  logic irq_match_hit;
  logic pwm_match_hit;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      compare_enable_reg <= 1'b0;
    end else if (load_strobe || compare_enable_clear) begin
      compare_enable_reg <= 1'b0;
    end else if (compare_enable_set) begin
      compare_enable_reg <= 1'b1;
    end
  end
  assign compare_enable = compare_enable_reg;

  // Conditions are evaluated on the value just reached, never on the start value
  assign roll_hit = cfg.count_up ? ((count_next & len_mask) == len_mask)
                                 : ((count_next & len_mask) == 10'h000);
  assign irq_match_hit = (count_next & irq_mask) == (preset_compare_value & irq_mask);
  assign pwm_match_hit = (count_next & len_mask) == (preset_compare_value & len_mask);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rollover_irq <= 1'b0;
      match_irq <= 1'b0;
    end else begin
      rollover_irq <= count_step && roll_hit;
      match_irq <= count_step && compare_enable_reg && irq_match_hit;
    end
  end

  // Match stop holds the counter until software stops and restarts it, or until a load strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      auto_stop_reg <= 1'b0;
    end else if (!cfg.start || load_strobe) begin
      auto_stop_reg <= 1'b0;
    end else if (count_step && compare_enable_reg && irq_match_hit &&
                 cfg.full_width_compare_select && cfg.pwm_route_enable) begin
      auto_stop_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // PWM
  // ----------------------------------------------------------------
  logic pwm_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pwm_reg <= 1'b1;
    end else if (!compare_enable_reg) begin
      pwm_reg <= ~cfg.count_up;
    end else if (count_step && pwm_match_hit) begin
      pwm_reg <= ~cfg.count_up;
    end else if (count_step && roll_hit) begin
      pwm_reg <= cfg.count_up;
    end
  end

  assign portb_bit_three_pin = cfg.pwm_route_enable ? pwm_reg : portb_data_out;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_load_clears_cmp: assert property (@(posedge mclk) disable iff (rst)
    load_strobe |=> !compare_enable) else $error("compare enable survived load");
  a_load_copies: assert property (@(posedge mclk) disable iff (rst)
    load_strobe |=> count_value == $past(preset_compare_value)) else $error("load lost");
  a_no_match_off: assert property (@(posedge mclk) disable iff (rst)
    !compare_enable |=> !match_irq) else $error("match while compare off");
  a_pwm_idle_level: assert property (@(posedge mclk) disable iff (rst)
    !compare_enable ##1 !compare_enable |-> pwm_reg == ~$past(cfg.count_up))
    else $error("pwm start level wrong");
  a_route_pwm: assert property (@(posedge mclk) disable iff (rst)
    cfg.pwm_route_enable |-> portb_bit_three_pin == pwm_reg) else $error("pwm not routed");
  a_roll_cause: assert property (@(posedge mclk) disable iff (rst)
    rollover_irq |-> $past(count_step)) else $error("rollover without step");
  a_stopped_hold: assert property (@(posedge mclk) disable iff (rst)
    (!cfg.start && !load_strobe && cfg.count_up == count_up_prev_reg) |=> $stable(count_value))
    else $error("counted while stopped");
  a_auto_stop: assert property (@(posedge mclk) disable iff (rst)
    auto_stop_reg && !load_strobe && cfg.count_up == count_up_prev_reg |=> $stable(count_value))
    else $error("counted after match stop");
  a_ev_start: assert property (@(posedge mclk) disable iff (rst)
    run_gate && cfg.event_count_enable |=> running_reg) else $error("event start late");
  a_match_cause: assert property (@(posedge mclk) disable iff (rst)
    match_irq |-> $past(count_step) && $past(compare_enable_reg)) else $error("match without step");
  // Rollover alone sets the level of the count direction; a coinciding match wins
  a_pwm_roll_level: assert property (@(posedge mclk) disable iff (rst)
    count_step && compare_enable_reg && roll_hit && !pwm_match_hit |=> pwm_reg == $past(cfg.count_up))
    else $error("pwm rollover level wrong");

  // Main scenarios
  c_event_start: cover property (@(posedge mclk) disable iff (rst)
    $rose(running_reg) && cfg.event_count_enable);
  c_rollover: cover property (@(posedge mclk) disable iff (rst) rollover_irq);
  c_match: cover property (@(posedge mclk) disable iff (rst) match_irq);
  c_auto_stop: cover property (@(posedge mclk) disable iff (rst) $rose(auto_stop_reg));
  c_pwm_toggle: cover property (@(posedge mclk) disable iff (rst)
    compare_enable && $changed(pwm_reg));

endmodule : cyclic_counter_compare_pwm
`default_nettype wire

/* File: testbench/porta_pwm_partner.sv */
// Port-A pulse source and PWM pin watcher
`timescale 1ns/10ps
`default_nettype none
module porta_pwm_partner (
  // Port-A pins, pulled low when idle
  output logic porta_bit_zero_pin,
  output logic porta_bit_three_pin,
  // Port-B bit three pin
  input wire logic portb_bit_three_pin
);
  int pwm_rises = 0;
  initial begin
    {porta_bit_three_pin, porta_bit_zero_pin} = 2'h0;
  end
  // Pulses far slower than the pin sync, so no edge is ever dropped
  task automatic send_pulses(input logic sel, input int n);
    for (int i = 0; i < n; i++) begin
      {porta_bit_three_pin, porta_bit_zero_pin} = sel ? 2'h2 : 2'h1;
      #300;
      {porta_bit_three_pin, porta_bit_zero_pin} = 2'h0;
      #300;
    end
  endtask : send_pulses
  always @(posedge portb_bit_three_pin) pwm_rises++;
endmodule : porta_pwm_partner
`default_nettype wire

/* File: testbench/cyclic_counter_compare_pwm_tb_top.sv */
// Directed testbench for the cyclic counter with compare and PWM
`timescale 1ns/10ps
`default_nettype none
module cyclic_counter_compare_pwm_tb_top;
  import cyclic_counter_pkg::*;
  logic mclk, rst, ld, ce_set, ce_clr, pb_data, pb3, pa0, pa3, ce, stc, roll, mat;
  logic [9:0] preset, cnt;
  logic [5:0] tap;
  logic [1:0] dtick;
  counter_config_t cfg;
  porta_option_t opt;
  int failures = 0;
  int n_compared = 0;
  int n_roll = 0;
  int n_match = 0;
  int n_stc = 0;
  cyclic_counter_compare_pwm u_cyclic_counter_compare_pwm (.mclk(mclk), .rst(rst),
    .cfg(cfg), .porta_opt(opt), .preset_compare_value(preset), .load_strobe(ld),
    .compare_enable_set(ce_set), .compare_enable_clear(ce_clr), .presc_tap(tap),
    .debounce_tick(dtick), .porta_bit_zero_pin(pa0), .porta_bit_three_pin(pa3),
    .portb_data_out(pb_data), .portb_bit_three_pin(pb3), .count_value(cnt),
    .compare_enable(ce), .start_cleared(stc), .rollover_irq(roll), .match_irq(mat));
  porta_pwm_partner u_porta_pwm_partner (.porta_bit_zero_pin(pa0),
    .porta_bit_three_pin(pa3), .portb_bit_three_pin(pb3));
  // ----------------------------------------
  // Clock, event counters and tasks
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(negedge mclk) dtick <= ~dtick;
  always @(posedge mclk) begin
    if (roll === 1'b1) n_roll++;
    if (mat === 1'b1) n_match++;
    if (stc === 1'b1) n_stc++;
  end
  task automatic end_sim;
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  // Taps run at mclk/8, well under the mclk/2 limit
  task automatic tick(input int n);
    repeat (n) begin
      tap = 6'h3F;
      cyc(4);
      tap = 6'h00;
      cyc(4);
    end
  endtask : tick
  task automatic load(input logic [9:0] v);
    preset = v;
    ld = 1'b1;
    cyc(1);
    ld = 1'b0;
    cyc(3);
  endtask : load
  task automatic enable_cmp(input logic [9:0] v);
    preset = v;
    ce_set = 1'b1;
    cyc(1);
    ce_set = 1'b0;
    cyc(3);
  endtask : enable_cmp
  task automatic clr;
    n_roll = 0;
    n_match = 0;
    u_porta_pwm_partner.pwm_rises = 0;
  endtask : clr
  initial begin
    #2000000;
    failures++;
    end_sim();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {rst, ld, ce_set, ce_clr, pb_data} = 5'h11;
    {preset, tap, dtick, opt} = 22'h1;
    cfg = '0;
    cyc(8);
    rst = 1'b0;
    cyc(2);
    chk(cnt, 10'h000);
    chk(10'(ce), 10'h000);
    chk(10'(pb3), 10'h001);
    pb_data = 1'b0;
    cyc(1);
    chk(10'(pb3), 10'h000);
    // Down count, 4-bit length, upper bits ignored for rollover
    cfg = '{3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h3};
    load(10'h102);
    chk(cnt, 10'h102);
    chk(10'(pb3), 10'h001);
    cfg.start = 1'b1;
    clr();
    tick(2);
    chk(cnt, 10'h102);
    tick(2);
    chk(cnt, 10'h100);
    chk(10'(n_roll), 10'h001);
    chk(10'(n_match), 10'h000);
    // Up count, full compare, five PWM pulses then auto-stop
    cfg = '{3'h1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 2'h3};
    load(10'h000);
    chk(10'(pb3), 10'h000);
    enable_cmp(10'h052);
    chk(10'(ce), 10'h001);
    cfg.start = 1'b1;
    clr();
    tick(100);
    chk(cnt, 10'h052);
    chk(10'(n_match), 10'h001);
    chk(10'(n_roll), 10'h005);
    chk(10'(u_porta_pwm_partner.pwm_rises), 10'h005);
    chk(10'(pb3), 10'h000);
    // Limited compare keeps counting, no match on the start value
    cfg = '{3'h1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h3};
    load(10'h005);
    enable_cmp(10'h005);
    cfg.start = 1'b1;
    clr();
    tick(2);
    chk(10'(n_match), 10'h000);
    tick(17);
    chk(cnt, 10'h016);
    chk(10'(n_match), 10'h001);
    chk(10'(n_roll), 10'h001);
    load(10'h010);
    chk(10'(ce), 10'h000);
    // Undebounced event count on each pin, the second one inverted
    for (int p = 0; p < 2; p++) begin
      cfg = '{p ? 3'h7 : 3'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0};
      opt = {p ? 2'h2 : 2'h0, 2'h3};
      cyc(10);
      load(10'h010);
      cfg.start = 1'b1;
      u_porta_pwm_partner.send_pulses(p[0], 8);
      cyc(10);
      chk(cnt, 10'h014);
    end
    // Debounced event count on PA0 steps on every pulse
    cfg = '{3'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0};
    opt = 4'h0;
    cyc(10);
    load(10'h010);
    cfg.start = 1'b1;
    u_porta_pwm_partner.send_pulses(1'b0, 8);
    cyc(10);
    chk(cnt, 10'h018);
    chk(10'(n_stc), 10'h001);
    end_sim();
  end
endmodule : cyclic_counter_compare_pwm_tb_top
`default_nettype wire
